// ### srst_regs.svh
/*
 Offsets, field positions, reset values and timing counts of the soft reset block.
 Assumes a 250 MHz system clock and an AXI4-Lite register port.
*/
`ifndef SRST_REGS_SVH
`define SRST_REGS_SVH
`define SRST_CTL_OFFSET      12'h1f8
`define SRST_STAT_OFFSET     12'h1fc
`define SRST_BIT_DIGITAL     0
`define SRST_BIT_PORT1       1
`define SRST_BIT_PORT2       2
`define SRST_BIT_VPHY        3
`define SRST_CTL_RESET       4'h0
`define SRST_PHY_HOLD_US     102
`define SRST_CLK_MHZ         250
`define SRST_PHY_HOLD_CYC    (`SRST_PHY_HOLD_US * `SRST_CLK_MHZ)
`define SRST_DIG_HOLD_CYC    16
`define SRST_VPHY_HOLD_CYC   16
`define SRST_RESP_OKAY       2'h0
`define SRST_RESP_SLVERR     2'h2
`endif

// ### srst_pkg.sv
/*
 Types shared by the soft reset block.
 Assumes srst_regs.svh holds the numeric constants.
*/
package srst_pkg;
	typedef logic [14:0] srst_cnt_t;
	typedef enum logic [1:0] {
		SRST_IDLE = 2'b00,
		SRST_HOLD = 2'b01,
		SRST_WAIT = 2'b10
	} srst_state_t;
	typedef struct packed {
		srst_state_t state;
		srst_cnt_t   cnt;
		logic        req;
		logic        rst;
	} srst_chan_t;
endpackage : srst_pkg

// ### srst_chan.sv
/*
 One reset channel: a self-clearing request bit that drives a reset for a
 minimum hold time and clears once the target reports it has left reset.
 Assumes done_in comes from logic on mclk.
*/
`timescale 1ns/10ps
`include "srst_regs.svh"
module srst_chan #(
	parameter srst_pkg::srst_cnt_t HOLD = 15'h0001
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Request and target
	input  wire logic set_in,
	input  wire logic done_in,
	output logic      req_out,
	output logic      rst_out
);
	import srst_pkg::*;
	srst_chan_t ch_reg;
	srst_chan_t ch_next;

	always_comb begin
		ch_next = ch_reg;
		unique case (ch_reg.state)
			SRST_IDLE: begin
				// A write while the bit reads one never reaches here
				if (set_in) begin
					ch_next.state = SRST_HOLD;
					ch_next.req   = 1'b1;
					ch_next.rst   = 1'b1;
					ch_next.cnt   = HOLD;
				end
			end
			SRST_HOLD: begin
				if (ch_reg.cnt == 15'h0001) begin
					ch_next.rst   = 1'b0;
					ch_next.state = SRST_WAIT;
				end else begin
					ch_next.cnt = ch_reg.cnt - 15'h0001;
				end
			end
			SRST_WAIT: begin
				// Bit clears only after the target is out of reset
				if (done_in) begin
					ch_next.req   = 1'b0;
					ch_next.state = SRST_IDLE;
				end
			end
			default: begin
				ch_next = '0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ch_reg <= '0;
		end else begin
			ch_reg <= ch_next;
		end
	end

	assign req_out = ch_reg.req;
	assign rst_out = ch_reg.rst;
endmodule : srst_chan

// ### srst_ctl.sv
/*
 Software reset control: AXI4-Lite register with per-PHY, virtual PHY and
 digital reset requests, plus EEPROM abort and configuration reload.
 Assumes rst_n is the master reset; target ready inputs may come from any clock.
*/
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "srst_regs.svh"
module srst_ctl (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Reset targets
	input  wire logic        port1_phy_ready,
	input  wire logic        port2_phy_ready,
	input  wire logic        virtual_phy_ready,
	input  wire logic        digital_ready,
	output logic             port1_phy_rst,
	output logic             port2_phy_rst,
	output logic             virtual_phy_rst,
	output logic             digital_rst,
	output logic             csr_default_n,
	// EEPROM loader
	input  wire logic        eeprom_busy,
	output logic             eeprom_abort,
	output logic             eeprom_reload
);
	import srst_pkg::*;

	// Word indices of the two registers; the low address bits only pick bytes
	localparam logic [9:0] CTL_WORD  = 10'(`SRST_CTL_OFFSET >> 2);
	localparam logic [9:0] STAT_WORD = 10'(`SRST_STAT_OFFSET >> 2);

	typedef struct packed {
		logic        aw_got;
		logic [11:0] aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        dig_prev;
		logic        abort;
		logic        reload;
	} srst_ctl_t;

	srst_ctl_t st_reg;
	srst_ctl_t st_next;

	logic [3:0] set_req;
	logic [3:0] req_bits;
	logic [3:0] rst_bits;
	logic [3:0] done_bits;
	logic       wr_fire;
	logic       wr_ctl;
	// Address decode of the latched write and of the live read
	logic       wr_hit;
	logic       rd_ctl;
	logic       rd_stat;
	logic       rd_hit;

	// Ready inputs come from pins; two flops each before use
	logic [3:0] rdy_meta_reg;
	logic [3:0] rdy_sync_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_meta_reg <= 4'h0;
			rdy_sync_reg <= 4'h0;
		end else begin
			rdy_meta_reg <= {virtual_phy_ready, port2_phy_ready, port1_phy_ready, digital_ready};
			rdy_sync_reg <= rdy_meta_reg;
		end
	end

	assign done_bits = rdy_sync_reg;

	// This port is the host path only; the EEPROM loader has no write port here
	// A new write waits for the last response to be taken
	assign wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
	assign wr_hit  = (st_reg.aw_addr[11:2] == CTL_WORD) || (st_reg.aw_addr[11:2] == STAT_WORD);
	// Byte lane 0 carries every request bit; other lanes alone change nothing
	assign wr_ctl  = wr_fire && (st_reg.aw_addr[11:2] == CTL_WORD) && st_reg.w_strb[0];
	// Read decode looks at the live address, sampled at the edge that takes it
	assign rd_ctl  = (s_axi_araddr[11:2] == CTL_WORD);
	assign rd_stat = (s_axi_araddr[11:2] == STAT_WORD);
	assign rd_hit  = rd_ctl || rd_stat;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			// Only the port PHYs need the long count; the other holds are short by choice
			localparam srst_cnt_t HOLD = (gi == `SRST_BIT_PORT1 || gi == `SRST_BIT_PORT2) ?
				srst_cnt_t'(`SRST_PHY_HOLD_CYC) :
				(gi == `SRST_BIT_VPHY) ? srst_cnt_t'(`SRST_VPHY_HOLD_CYC) : srst_cnt_t'(`SRST_DIG_HOLD_CYC);
			// Writes while the bit reads one are dropped
			assign set_req[gi] = wr_ctl && st_reg.w_data[gi] && !req_bits[gi];
			srst_chan #(
				.HOLD (HOLD)
			) u_chan (
				.mclk    (mclk),
				.rst_n   (rst_n),
				.set_in  (set_req[gi]),
				.done_in (done_bits[gi]),
				.req_out (req_bits[gi]),
				.rst_out (rst_bits[gi])
			);
		end
	endgenerate

	// Every reset output is a channel flop or its inverse, so none glitches on a register write
	assign port1_phy_rst   = rst_bits[`SRST_BIT_PORT1];
	assign port2_phy_rst   = rst_bits[`SRST_BIT_PORT2];
	assign virtual_phy_rst = rst_bits[`SRST_BIT_VPHY];
	// Digital reset reaches no PHY or PLL output
	assign digital_rst     = rst_bits[`SRST_BIT_DIGITAL];
	assign csr_default_n   = !rst_bits[`SRST_BIT_DIGITAL];
	assign eeprom_abort    = st_reg.abort;
	assign eeprom_reload   = st_reg.reload;

	always_comb begin
		st_next = st_reg;

		// AW and W are latched on their own, so either may arrive first
		if (s_axi_awvalid && !st_reg.aw_got) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_got) begin
			st_next.w_got  = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end

		// The write runs one cycle after both halves are held
		if (wr_fire) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = wr_hit ? `SRST_RESP_OKAY : `SRST_RESP_SLVERR;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Read data is latched with rvalid, so it stands until rready
		if (s_axi_arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = rd_hit ? `SRST_RESP_OKAY : `SRST_RESP_SLVERR;
			if (rd_ctl) begin
				st_next.rdata = {28'h0000000, req_bits};
			end else if (rd_stat) begin
				st_next.rdata = {27'h0000000, eeprom_busy, rst_bits};
			end else begin
				st_next.rdata = 32'h00000000;
			end
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		// Abort follows the digital reset one cycle late and outlasts it by a cycle, so a command
		// started late is still killed; reload pulses once on release.
		st_next.dig_prev = rst_bits[`SRST_BIT_DIGITAL];
		st_next.abort    = rst_bits[`SRST_BIT_DIGITAL];
		st_next.reload   = st_reg.dig_prev && !rst_bits[`SRST_BIT_DIGITAL];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Each ready is the inverse of a held slot: one read in flight at most, and two writes, one held while one awaits its response
	assign s_axi_awready = !st_reg.aw_got;
	assign s_axi_wready  = !st_reg.w_got;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;
endmodule : srst_ctl

// ### srst_sva.sv
/* Checker on srst_ctl ports.
 Assumes one mclk domain; bound into srst_ctl at the foot. */
`timescale 1ns/10ps
`include "srst_regs.svh"
module srst_sva (
	input wire logic mclk, rst_n,
	input wire logic port1_phy_rst, port2_phy_rst, virtual_phy_rst, digital_rst,
	input wire logic csr_default_n, eeprom_abort, eeprom_reload
);
	logic [15:0] c1, c2;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			c1 <= '0;
			c2 <= '0;
		end else begin
			c1 <= port1_phy_rst ? c1 + 16'h1 : '0;
			c2 <= port2_phy_rst ? c2 + 16'h1 : '0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence reload_pulse;
		##[1:3] eeprom_reload ##1 !eeprom_reload;
	endsequence
	// Past of rst_n keeps a mid-run reset from reading as a release
	// The count one cycle back has seen one edge less than the whole hold
	AST_P1_HOLD: assert property ($past(rst_n) && $fell(port1_phy_rst) |-> $past(c1) >= 16'(`SRST_PHY_HOLD_CYC - 1))
		else $error("port 1 reset too short");
	AST_P2_HOLD: assert property ($past(rst_n) && $fell(port2_phy_rst) |-> $past(c2) >= 16'(`SRST_PHY_HOLD_CYC - 1))
		else $error("port 2 reset too short");
	AST_VP_HOLD: assert property ($rose(virtual_phy_rst) |-> virtual_phy_rst[*8])
		else $error("virtual reset too short");
	AST_DIG_HOLD: assert property ($rose(digital_rst) |-> digital_rst[*8])
		else $error("digital reset too short");
	AST_ABORT: assert property (digital_rst |=> eeprom_abort)
		else $error("no abort");
	AST_CSR: assert property ($rose(digital_rst) |-> ##[0:1] !csr_default_n)
		else $error("no csr default");
	AST_SPARE: assert property (digital_rst |-> !$rose(port1_phy_rst) && !$rose(port2_phy_rst))
		else $error("phy reset by digital");
	AST_RELOAD: assert property ($past(rst_n) && $fell(digital_rst) |-> reload_pulse)
		else $error("no reload pulse");
endmodule : srst_sva
bind srst_ctl srst_sva srst_sva_i (.mclk, .rst_n, .port1_phy_rst, .port2_phy_rst, .virtual_phy_rst,
	.digital_rst, .csr_default_n, .eeprom_abort, .eeprom_reload);

// ### srst_far.sv
/* Far side model: reset targets and EEPROM loader.
 Assumes mclk domain; targets leave reset two cycles after release. */
`timescale 1ns/10ps
module srst_far (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [3:0] rsts,
	input  wire logic       start,
	input  wire logic       abort,
	input  wire logic       reload,
	output logic [3:0]      ready,
	output logic            busy
);
	logic [3:0] q;
	// Loader stays busy until aborted, the harsher case for the host
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			ready <= '0;
			busy <= 1'b0;
		end else begin
			q <= ~rsts;
			ready <= q;
			if (abort)
				busy <= 1'b0;
			else if (start || reload)
				busy <= 1'b1;
		end
	end
endmodule : srst_far

// ### tb_top.sv
/* Bench top: srst_ctl over AXI4-Lite with srst_far as targets.
 Assumes srst_regs.svh constants. */
`timescale 1ns/10ps
`include "srst_regs.svh"
module tb_top;
	logic        mclk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, bry = 0, rry = 0, go = 0;
	logic        awr, wrd, arr, bv, rv, csr_n, abt, rld, busy;
	logic [1:0]  br, rr, rs;
	logic [3:0]  ro, rdy, ws = 4'hf;
	logic [11:0] ad = '0;
	logic [31:0] wd = '0, rdat, rd, seed = 32'h000113a2;
	int          failures = 0, n_checks = 0, n, k, mdl_req = 0;
	localparam logic [11:0] C = `SRST_CTL_OFFSET, S = `SRST_STAT_OFFSET;
	localparam logic [1:0] OK = `SRST_RESP_OKAY, ERR = `SRST_RESP_SLVERR;
	initial forever #2 mclk = ~mclk;
	srst_ctl srst_ctl_i (.mclk, .rst_n, .s_axi_awaddr(ad), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ad), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.port1_phy_ready(rdy[1]), .port2_phy_ready(rdy[2]), .virtual_phy_ready(rdy[3]), .digital_ready(rdy[0]),
		.port1_phy_rst(ro[1]), .port2_phy_rst(ro[2]), .virtual_phy_rst(ro[3]), .digital_rst(ro[0]),
		.csr_default_n(csr_n), .eeprom_busy(busy), .eeprom_abort(abt), .eeprom_reload(rld));
	srst_far srst_far_i (.mclk, .rst_n, .rsts(ro), .start(go), .abort(abt), .reload(rld), .ready(rdy), .busy);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tmo(input int v, input int lim);
		if (v >= lim) begin
			failures++;
			complete_run();
		end
	endtask : tmo
	// Handshakes sampled at the falling edge so no race with the design
	task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		logic ta, tw, dn;
		dn = 0;
		@(posedge mclk);
		ad <= a;
		wd <= d;
		awv <= w;
		wv <= w;
		arv <= !w;
		bry <= w;
		rry <= !w;
		for (i = 0; i < 99 && !dn; i++) begin
			@(negedge mclk);
			ta = w ? awr : arr;
			tw = wrd;
			dn = w ? bv : rv;
			rs = w ? br : rr;
			rd = rdat;
			@(posedge mclk);
			if (ta) begin
				awv <= 0;
				arv <= 0;
			end
			if (tw)
				wv <= 0;
			if (dn) begin
				bry <= 0;
				rry <= 0;
			end
		end
		tmo(i, 99);
	endtask : axi
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		axi(0, a, 0);
		chk(rd, e, "rdata");
		chk(rs, er, "rresp");
	endtask : rdc
	// Bench model of the request bits: a one sets a clear bit, a set bit ignores the write
	task automatic wctl(input logic [31:0] d);
		axi(1, C, d);
		chk(rs, OK, "bresp");
		mdl_req |= int'(d & 32'hf);
	endtask : wctl
	task automatic wfall(input int b);
		for (n = 0; n < 30000 && ro[b] !== 1'b0; n++)
			@(negedge mclk);
		tmo(n, 30000);
		// Request clears once the target is out of reset; reads come a few cycles later
		mdl_req &= ~(1 << b);
	endtask : wfall
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1;
		rdc(C, 0, OK);
		rdc(S, 0, OK);
		rdc(12'h100, 0, ERR);
		axi(1, 12'h104, xs());
		chk(rs, ERR, "bresp");
		wctl(xs() & 32'hfffffff0);
		ws <= 4'he;
		axi(1, C, 32'hf);
		ws <= 4'hf;
		chk(rs, OK, "bresp");
		rdc(C, mdl_req, OK);
		$display("test map done");
		go <= 1;
		@(posedge mclk);
		go <= 0;
		rdc(S, 32'h10, OK);
		wctl(1);
		rdc(S, 1, OK);
		@(negedge mclk);
		chk(csr_n, 0, "csr_default_n");
		chk(abt, 1, "eeprom_abort");
		wfall(0);
		for (k = 0; k < 99 && rld !== 1'b1; k++)
			@(negedge mclk);
		tmo(k, 99);
		for (k = 0; k < 50; k++) begin
			axi(0, C, 0);
			if (rd[0] === 1'b0)
				break;
		end
		tmo(k, 50);
		rdc(C, mdl_req, OK);
		@(negedge mclk);
		chk(csr_n, 1, "csr_default_n");
		chk(abt, 0, "eeprom_abort");
		$display("test digital done");
		wctl(2);
		wctl(6);
		rdc(C, mdl_req, OK);
		wfall(1);
		chk(n >= `SRST_PHY_HOLD_CYC - 8, 1, "hold");
		wfall(2);
		repeat (12) @(posedge mclk);
		rdc(C, mdl_req, OK);
		wctl(8);
		rdc(S, 32'h18, OK);
		wfall(3);
		repeat (12) @(posedge mclk);
		rdc(C, mdl_req, OK);
		$display("test phy done");
		complete_run();
	end
endmodule : tb_top
